// ---- rtl/fcd_pkg.sv ----
// package: shared constants and types of the four-clock instruction decoder
package fcd_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int FCD_CLK_PER_CYC = 4;
  localparam int FCD_MAX_CYC = 5;

  // ---------------------------------------------------------------
  // reset values and fixed addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] FCD_PC_RST = 16'h0000;
  localparam logic [7:0] FCD_ACC_RST = 8'h00;
  localparam logic [7:0] FCD_B_RST = 8'h00;
  localparam logic [7:0] FCD_B_ADDR = 8'hf0;
  localparam logic [4:0] FCD_BANK_BASE = 5'h00;
  localparam logic [6:0] FCD_PTR_BASE = 7'h00;

  // ---------------------------------------------------------------
  // opcodes named by the sequencer and its checks
  // ---------------------------------------------------------------
  localparam logic [7:0] FCD_OPC_MUL = 8'ha4;
  localparam logic [7:0] FCD_OPC_DIV = 8'h84;
  localparam logic [7:0] FCD_OPC_SJMP = 8'h80;
  localparam logic [7:0] FCD_OPC_RL = 8'h23;
  localparam logic [7:0] FCD_OPC_RRC = 8'h13;
  localparam logic [7:0] FCD_OPC_LDI_ACC = 8'h74;
  localparam logic [7:0] FCD_OPC_SUM_WITH_CARRY_IMM = 8'h34;
  localparam logic [7:0] FCD_OPC_AND_DIR_IMM = 8'h53;

  // ---------------------------------------------------------------
  // decoded operation fields
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ALU_NONE, ALU_ADD, ALU_SUM_WITH_CARRY, ALU_SUBTRACT_WITH_BORROW, ALU_AND, ALU_OR, ALU_XOR,
    ALU_MOV, ALU_RL, ALU_RLC, ALU_RR, ALU_RRC, ALU_MUL, ALU_DIV, ALU_JMP
  } fcd_alu_e;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM, SRC_ACC
  } fcd_src_e;

  typedef enum logic [1:0] {
    DST_NONE, DST_ACC, DST_REG, DST_DIR
  } fcd_dst_e;

  typedef struct packed {
    fcd_alu_e alu;
    fcd_src_e src;
    fcd_dst_e dst;
    logic [1:0] len;
    logic [2:0] cyc;
    logic legal;
  } fcd_dec_s;

  // signed offset byte added to a program counter
  function automatic logic [15:0] fcd_rel_target(input logic [15:0] pc,
                                                  input logic [7:0] off);
    return pc + {{8{off[7]}}, off};
  endfunction : fcd_rel_target

endpackage : fcd_pkg

// ---- rtl/fcd_dmem.sv ----
// memory: single-port internal data ram with registered read data
module fcd_dmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // access port
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  import fcd_pkg::*;

  logic [DW-1:0] mem_r [2**AW];
  logic [DW-1:0] rdata_nxt;

  // read returns the old word on a same-cycle write
  always_comb begin
    rdata_nxt = mem_r[addr_i];
  end

  // array has no reset, contents stay undefined until written
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  // read register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

endmodule : fcd_dmem

// ---- rtl/fcd_decode.sv ----
// decoder: opcode byte to operation, operand mode, length and cycle count
module fcd_decode (
  // opcode in
  input wire logic [7:0] opc_i,
  // decoded fields
  output fcd_pkg::fcd_dec_s dec_o
);
  import fcd_pkg::*;

  fcd_alu_e alu;
  logic log_grp;

  // one legal table row
  function automatic fcd_dec_s row(input fcd_alu_e a, input fcd_src_e s,
                                   input fcd_dst_e d, input logic [1:0] l,
                                   input logic [2:0] c);
    return '{alu: a, src: s, dst: d, len: l, cyc: c, legal: 1'b1};
  endfunction : row

  always_comb begin
    dec_o = '{alu: ALU_NONE, src: SRC_NONE, dst: DST_NONE,
              len: 2'd1, cyc: 3'd1, legal: 1'b0};
    log_grp = (opc_i[7:6] == 2'b01) && (opc_i[5:4] != 2'b11);
    // accumulator groups share one low-nibble layout
    case (opc_i[7:4])
      4'h2: alu = ALU_ADD;
      4'h3: alu = ALU_SUM_WITH_CARRY;
      4'h9: alu = ALU_SUBTRACT_WITH_BORROW;
      4'h5: alu = ALU_AND;
      4'h4: alu = ALU_OR;
      4'h6: alu = ALU_XOR;
      4'he: alu = ALU_MOV;
      default: alu = ALU_NONE;
    endcase
    if (alu != ALU_NONE) begin
      casez (opc_i[3:0])
        4'b1???: dec_o = row(alu, SRC_REG, DST_ACC, 2'd1, 3'd1);
        4'h4: begin
          if (opc_i[7:4] != 4'he) begin
            dec_o = row(alu, SRC_IMM, DST_ACC, 2'd2, 3'd2);
          end
        end
        4'h5: dec_o = row(alu, SRC_DIR, DST_ACC, 2'd2, 3'd2);
        4'b011?: dec_o = row(alu, SRC_IND, DST_ACC, 2'd1, 3'd1);
        // 0x62 takes the two-byte form, not the printed duplicate
        4'h2: if (log_grp) dec_o = row(alu, SRC_ACC, DST_DIR, 2'd2, 3'd2);
        4'h3: if (log_grp) dec_o = row(alu, SRC_IMM, DST_DIR, 2'd3, 3'd3);
        default: ;
      endcase
    end
    // single opcodes and register-move ranges
    casez (opc_i)
      8'h00: dec_o = row(ALU_NONE, SRC_NONE, DST_NONE, 2'd1, 3'd1);
      8'h33: dec_o = row(ALU_RLC, SRC_NONE, DST_ACC, 2'd1, 3'd1);
      8'h23: dec_o = row(ALU_RL, SRC_NONE, DST_ACC, 2'd1, 3'd1);
      8'h13: dec_o = row(ALU_RRC, SRC_NONE, DST_ACC, 2'd1, 3'd1);
      8'h03: dec_o = row(ALU_RR, SRC_NONE, DST_ACC, 2'd1, 3'd1);
      8'h74: dec_o = row(ALU_MOV, SRC_IMM, DST_ACC, 2'd2, 3'd2);
      8'ha4: dec_o = row(ALU_MUL, SRC_NONE, DST_ACC, 2'd1, 3'd5);
      8'h84: dec_o = row(ALU_DIV, SRC_NONE, DST_ACC, 2'd1, 3'd5);
      8'h80: dec_o = row(ALU_JMP, SRC_IMM, DST_NONE, 2'd2, 3'd3);
      8'hf5: dec_o = row(ALU_MOV, SRC_ACC, DST_DIR, 2'd2, 3'd2);
      8'b1111_1???: dec_o = row(ALU_MOV, SRC_ACC, DST_REG, 2'd1, 3'd1);
      8'b1010_1???: dec_o = row(ALU_MOV, SRC_DIR, DST_REG, 2'd2, 3'd2);
      8'b0111_1???: dec_o = row(ALU_MOV, SRC_IMM, DST_REG, 2'd2, 3'd2);
      8'b1000_1???: dec_o = row(ALU_MOV, SRC_REG, DST_DIR, 2'd2, 3'd2);
      default: ;
    endcase
  end

endmodule : fcd_decode

// ---- rtl/fcd_core.sv ----
// top: four-clock instruction fetch, decode and execute sequencer
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module fcd_core (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // code memory fetch
  output logic [15:0] code_addr_o,
  output logic code_rd_o,
  input wire logic [7:0] code_data_i,
  // core state
  output logic [15:0] pc_o,
  output logic [7:0] acc_o,
  output logic carry_o,
  output logic ovf_o,
  output logic instr_done_o,
  output logic illegal_o
);
  import fcd_pkg::*;

  typedef enum logic [2:0] {
    S_BOOT, S_OPC, S_REQ, S_CAP, S_PTR, S_RD, S_EXE, S_WAIT
  } fcd_state_e;

  // ---------------------------------------------------------------
  // decode and data memory
  // ---------------------------------------------------------------
  fcd_dec_s dec_in;
  logic mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wd;
  logic [7:0] mem_q;

  fcd_decode u_dec (
    .opc_i(code_data_i),
    .dec_o(dec_in)
  );

  fcd_dmem #(
    .AW(8),
    .DW(8)
  ) u_dmem (
    .clk_i(sys_clk_i),
    .srst_i(srst_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wd),
    .rdata_o(mem_q)
  );

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  fcd_state_e state_r, state_nxt;
  fcd_dec_s dec_r, dec_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [7:0] b1_r, b1_nxt;
  logic [7:0] b2_r, b2_nxt;
  logic idx_r, idx_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] caddr_r, caddr_nxt;
  logic crd_r, crd_nxt;
  logic done_r, done_nxt;
  logic ill_r, ill_nxt;
  logic [4:0] last_w;
  logic final_w;
  logic [15:0] pc_use;

  // last clock of the instruction: cycles times four, minus one
  assign last_w = 5'(dec_r.cyc * FCD_CLK_PER_CYC - 1);
  assign final_w = (cnt_r == last_w) && ((state_r == S_EXE) || (state_r == S_WAIT));

  // next-state logic; the next opcode is requested in the final clock so
  // that its fetch overlaps and a one-cycle instruction fits in four clocks
  always_comb begin
    state_nxt = state_r;
    dec_nxt = dec_r;
    opc_nxt = opc_r;
    b1_nxt = b1_r;
    b2_nxt = b2_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r + 5'd1;
    pc_nxt = pc_r;
    caddr_nxt = caddr_r;
    crd_nxt = 1'b0;
    done_nxt = 1'b0;
    ill_nxt = ill_r;
    pc_use = pc_r;
    case (state_r)
      S_BOOT: begin
        crd_nxt = 1'b1;
        caddr_nxt = pc_r;
        pc_nxt = pc_r + 16'd1;
        state_nxt = S_OPC;
      end
      S_OPC: begin
        // opcode is on the bus this clock: clock 0 of the instruction
        opc_nxt = code_data_i;
        dec_nxt = dec_in;
        ill_nxt = !dec_in.legal;
        cnt_nxt = 5'd1;
        idx_nxt = 1'b0;
        if (dec_in.len > 2'd1) begin
          state_nxt = S_REQ;
        end else if (dec_in.src == SRC_IND) begin
          state_nxt = S_PTR;
        end else begin
          state_nxt = S_RD;
        end
      end
      S_REQ: begin
        crd_nxt = 1'b1;
        caddr_nxt = pc_r;
        pc_nxt = pc_r + 16'd1;
        state_nxt = S_CAP;
      end
      S_CAP: begin
        // operand bytes land in order: first, then second
        if (!idx_r) begin
          b1_nxt = code_data_i;
        end else begin
          b2_nxt = code_data_i;
        end
        idx_nxt = 1'b1;
        if (!idx_r && (dec_r.len == 2'd3)) begin
          state_nxt = S_REQ;
        end else if (dec_r.src == SRC_IND) begin
          state_nxt = S_PTR;
        end else begin
          state_nxt = S_RD;
        end
      end
      S_PTR: begin
        state_nxt = S_RD;
      end
      S_RD: begin
        state_nxt = S_EXE;
      end
      S_EXE, S_WAIT: begin
        if ((state_r == S_EXE) && (dec_r.alu == ALU_JMP)) begin
          pc_use = fcd_rel_target(pc_r, b1_r);
        end
        pc_nxt = pc_use;
        state_nxt = S_WAIT;
        if (final_w) begin
          // hold until the cycle budget is spent, then fetch the next opcode
          crd_nxt = 1'b1;
          caddr_nxt = pc_use;
          pc_nxt = pc_use + 16'd1;
          done_nxt = 1'b1;
          state_nxt = S_OPC;
        end
      end
      default: begin
        state_nxt = S_BOOT;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r <= S_BOOT;
      dec_r <= '0;
      opc_r <= 8'h00;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      idx_r <= 1'b0;
      cnt_r <= 5'h00;
      pc_r <= FCD_PC_RST;
      caddr_r <= FCD_PC_RST;
      crd_r <= 1'b0;
      done_r <= 1'b0;
      ill_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dec_r <= dec_nxt;
      opc_r <= opc_nxt;
      b1_r <= b1_nxt;
      b2_r <= b2_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      pc_r <= pc_nxt;
      caddr_r <= caddr_nxt;
      crd_r <= crd_nxt;
      done_r <= done_nxt;
      ill_r <= ill_nxt;
    end
  end

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  logic [7:0] acc_r, acc_nxt;
  logic cy_r, cy_nxt;
  logic ov_r, ov_nxt;
  logic [7:0] b_r, b_nxt;
  logic rdb_r, rdb_nxt;
  logic [7:0] reg_addr;
  logic [7:0] ptr_addr;
  logic [7:0] opnd, imm, lhs, rhs, res;
  logic [8:0] add9, sub9;
  logic [15:0] prod;
  logic cin;

  // bank registers sit at the bottom of data memory
  assign reg_addr = {FCD_BANK_BASE, opc_r[2:0]};
  assign ptr_addr = {FCD_PTR_BASE, opc_r[0]};

  // operand fetch, alu and write-back; one ram port, so reads happen in
  // S_PTR/S_RD and the single write in S_EXE
  always_comb begin
    acc_nxt = acc_r;
    cy_nxt = cy_r;
    ov_nxt = ov_r;
    b_nxt = b_r;
    rdb_nxt = 1'b0;
    mem_we = 1'b0;
    mem_addr = b1_r;
    opnd = rdb_r ? b_r : mem_q;
    imm = (dec_r.len == 2'd3) ? b2_r : b1_r;
    lhs = (dec_r.dst == DST_DIR) ? opnd : acc_r;
    case (dec_r.src)
      SRC_REG, SRC_DIR, SRC_IND: rhs = opnd;
      SRC_IMM: rhs = imm;
      SRC_ACC: rhs = acc_r;
      default: rhs = 8'h00;
    endcase
    cin = (dec_r.alu == ALU_SUM_WITH_CARRY) ? cy_r : 1'b0;
    add9 = {1'b0, lhs} + {1'b0, rhs} + {8'h00, cin};
    sub9 = {1'b0, lhs} - {1'b0, rhs} - {8'h00, cy_r};
    prod = 16'(acc_r) * 16'(b_r);
    res = lhs;
    case (state_r)
      S_PTR: mem_addr = ptr_addr;
      S_RD: begin
        if (dec_r.src == SRC_IND) begin
          mem_addr = mem_q;
        end else if (dec_r.src == SRC_REG) begin
          mem_addr = reg_addr;
        end else begin
          mem_addr = b1_r;
          rdb_nxt = (b1_r == FCD_B_ADDR);
        end
      end
      S_EXE: mem_addr = (dec_r.dst == DST_REG) ? reg_addr : b1_r;
      default: mem_addr = b1_r;
    endcase
    if (state_r == S_EXE) begin
      case (dec_r.alu)
        ALU_ADD, ALU_SUM_WITH_CARRY: begin
          res = add9[7:0];
          cy_nxt = add9[8];
        end
        ALU_SUBTRACT_WITH_BORROW: begin
          res = sub9[7:0];
          cy_nxt = sub9[8];
        end
        ALU_AND: res = lhs & rhs;
        ALU_OR: res = lhs | rhs;
        ALU_XOR: res = lhs ^ rhs;
        ALU_MOV: res = rhs;
        ALU_RL: res = {acc_r[6:0], acc_r[7]};
        ALU_RLC: begin
          res = {acc_r[6:0], cy_r};
          cy_nxt = acc_r[7];
        end
        ALU_RR: res = {acc_r[0], acc_r[7:1]};
        ALU_RRC: begin
          res = {cy_r, acc_r[7:1]};
          cy_nxt = acc_r[0];
        end
        ALU_MUL: begin
          res = prod[7:0];
          b_nxt = prod[15:8];
          cy_nxt = 1'b0;
          ov_nxt = |prod[15:8];
        end
        ALU_DIV: begin
          // divide by zero leaves a and b untouched and flags overflow
          cy_nxt = 1'b0;
          ov_nxt = (b_r == 8'h00);
          if (b_r != 8'h00) begin
            res = acc_r / b_r;
            b_nxt = acc_r % b_r;
          end else begin
            res = acc_r;
          end
        end
        default: res = lhs;
      endcase
      if (dec_r.dst == DST_ACC) begin
        acc_nxt = res;
      end
      if ((dec_r.dst == DST_DIR) && (b1_r == FCD_B_ADDR)) begin
        b_nxt = res;
      end
      // the b register shadows its direct address in ram
      mem_we = (dec_r.dst == DST_REG) ||
               ((dec_r.dst == DST_DIR) && (b1_r != FCD_B_ADDR));
    end
    mem_wd = res;
  end

  // datapath registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      acc_r <= FCD_ACC_RST;
      cy_r <= 1'b0;
      ov_r <= 1'b0;
      b_r <= FCD_B_RST;
      rdb_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      cy_r <= cy_nxt;
      ov_r <= ov_nxt;
      b_r <= b_nxt;
      rdb_r <= rdb_nxt;
    end
  end

  // outputs straight from registers
  assign code_addr_o = caddr_r;
  assign code_rd_o = crd_r;
  assign pc_o = pc_r;
  assign acc_o = acc_r;
  assign carry_o = cy_r;
  assign ovf_o = ov_r;
  assign instr_done_o = done_r;
  assign illegal_o = ill_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [4:0] since_r;
  logic seen_r;
  logic [7:0] acc_st;
  logic cy_st;
  logic [15:0] opa_st;

  // clocks between completions, and state at the start of each instruction
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      since_r <= 5'h00;
      seen_r <= 1'b0;
      acc_st <= 8'h00;
      cy_st <= 1'b0;
      opa_st <= 16'h0000;
    end else begin
      since_r <= done_r ? 5'd1 : since_r + 5'd1;
      seen_r <= seen_r | done_r;
      if (state_r == S_OPC) begin
        acc_st <= acc_r;
        cy_st <= cy_r;
        opa_st <= caddr_r;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_four_clk;
    done_r && seen_r |-> since_r == 5'(dec_r.cyc * FCD_CLK_PER_CYC);
  endproperty
  a_four_clk: assert property (p_four_clk) else $error("cycle not four clocks");

  property p_muldiv_five;
    done_r && seen_r && (opc_r == FCD_OPC_MUL || opc_r == FCD_OPC_DIV) |-> since_r == 5'd20;
  endproperty
  a_muldiv_five: assert property (p_muldiv_five) else $error("mul/div not 5 cycles");

  property p_three_byte;
    done_r && seen_r && (opc_r == FCD_OPC_AND_DIR_IMM) |-> since_r == 5'd12;
  endproperty
  a_three_byte: assert property (p_three_byte) else $error("53 not 3 cycles");

  property p_pc_step;
    code_rd_o |-> pc_o == code_addr_o + 16'd1 ##1 !code_rd_o;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc not one past fetch");

  property p_rl;
    done_r && (opc_r == FCD_OPC_RL) |-> acc_o == {acc_st[6:0], acc_st[7]};
  endproperty
  a_rl: assert property (p_rl) else $error("rotate left wrong");

  property p_rrc;
    done_r && (opc_r == FCD_OPC_RRC) |-> acc_o == {cy_st, acc_st[7:1]} && carry_o == acc_st[0];
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right via carry wrong");

  property p_ldi;
    done_r && (opc_r == FCD_OPC_LDI_ACC) |-> acc_o == b1_r;
  endproperty
  a_ldi: assert property (p_ldi) else $error("immediate load wrong");

  property p_sum_with_carry;
    done_r && (opc_r == FCD_OPC_SUM_WITH_CARRY_IMM) |-> acc_o == 8'(acc_st + b1_r + 8'(cy_st));
  endproperty
  a_sum_with_carry: assert property (p_sum_with_carry) else $error("add with carry wrong");

  property p_sjmp;
    done_r && (opc_r == FCD_OPC_SJMP) |-> code_addr_o == fcd_rel_target(opa_st + 16'd2, b1_r);
  endproperty
  a_sjmp: assert property (p_sjmp) else $error("relative target wrong");

endmodule : fcd_core

// ---- verification/fcd_cmem_model.sv ----
// code memory model: answers the core's fetch strobe inside the strobe cycle
module fcd_cmem_model (
  // clock
  input wire logic clk_i,
  // fetch port
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  initial begin
    data_o = 8'h5a;
  end
  // the core takes the byte at the rising edge that ends its strobe cycle, so the
  // byte is put out at the falling edge inside that cycle; otherwise the bus toggles
  always @(negedge clk_i) begin
    if (rd_i === 1'b1) begin
      data_o <= mem[addr_i[7:0]];
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : fcd_cmem_model

// ---- verification/tb_fcd_core.sv ----
// testbench: short programs through the core, checking timing, fetch order and results
module tb_fcd_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i;
  logic srst_i;
  logic [15:0] code_addr_o;
  logic code_rd_o;
  logic [7:0] code_data_i;
  logic [15:0] pc_o;
  logic [7:0] acc_o;
  logic carry_o;
  logic ovf_o;
  logic instr_done_o;
  logic illegal_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [15:0] exp_addr = 16'h0000;
  logic seq_on = 1'b1;

  fcd_core fcd_core_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .code_addr_o(code_addr_o),
    .code_rd_o(code_rd_o), .code_data_i(code_data_i), .pc_o(pc_o), .acc_o(acc_o),
    .carry_o(carry_o), .ovf_o(ovf_o), .instr_done_o(instr_done_o), .illegal_o(illegal_o));
  fcd_cmem_model fcd_cmem_model_i (.clk_i(sys_clk_i), .addr_i(code_addr_o),
    .rd_i(code_rd_o), .data_o(code_data_i));

  // 20 MHz core clock
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // every strobe: pc one past the address; addresses ascend unless a jump is under test
  always @(negedge sys_clk_i) begin
    if (!srst_i && code_rd_o === 1'b1) begin
      cmp("pc", code_addr_o + 16'h0001, pc_o);
      if (seq_on) cmp("fetch addr", exp_addr, code_addr_o);
      exp_addr = code_addr_o + 16'h0001;
    end
  end

  // reset, load a program from address 0 (rest is no-op), release and see the boot fetch
  task automatic ld(input logic [7:0] p[$]);
    @(negedge sys_clk_i);
    srst_i = 1'b1;
    for (int i = 0; i < 256; i++) fcd_cmem_model_i.mem[i] = (i < p.size()) ? p[i] : 8'h00;
    exp_addr = 16'h0000;
    repeat (2) @(negedge sys_clk_i);
    srst_i = 1'b0;
    @(negedge sys_clk_i);
    cmp("boot fetch", 16'h0001, {15'h0000, code_rd_o});
  endtask : ld

  // wait for the next completion; clocks since the last one must be four per cycle
  task automatic step(input int c, input logic [7:0] a, input logic cy);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (instr_done_o !== 1'b1 && n < 100);
    cmp("clocks", 16'(4 * c), 16'(n));
    cmp("acc", {8'h00, a}, {8'h00, acc_o});
    cmp("carry", {15'h0000, cy}, {15'h0000, carry_o});
  endtask : step

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_arith();
    ld({8'h74, 8'hf0, 8'h24, 8'h20, 8'h34, 8'h05, 8'h94, 8'h17, 8'h74, 8'h82,
        8'h13, 8'h33, 8'h23, 8'h03});
    step(2, 8'hf0, 1'b0);
    step(2, 8'h10, 1'b1);
    step(2, 8'h16, 1'b0);
    step(2, 8'hff, 1'b1);
    step(2, 8'h82, 1'b1);
    step(1, 8'hc1, 1'b0);
    step(1, 8'h82, 1'b1);
    step(1, 8'h05, 1'b1);
    step(1, 8'h82, 1'b1);
    $display("test arith done");
  endtask : t_arith

  task automatic t_logic();
    ld({8'h74, 8'h3c, 8'hf5, 8'h30, 8'h74, 8'h0f, 8'h55, 8'h30, 8'h45, 8'h30, 8'h64, 8'hff,
        8'h53, 8'h30, 8'ha5, 8'he5, 8'h30, 8'h43, 8'h30, 8'h81, 8'h63, 8'h30, 8'hff,
        8'h62, 8'h30, 8'he5, 8'h30, 8'h52, 8'h30, 8'he5, 8'h30});
    step(2, 8'h3c, 1'b0);
    step(2, 8'h3c, 1'b0);
    step(2, 8'h0f, 1'b0);
    step(2, 8'h0c, 1'b0);
    step(2, 8'h3c, 1'b0);
    step(2, 8'hc3, 1'b0);
    step(3, 8'hc3, 1'b0);
    step(2, 8'h24, 1'b0);
    step(3, 8'h24, 1'b0);
    step(3, 8'h24, 1'b0);
    step(2, 8'h24, 1'b0);
    step(2, 8'h7e, 1'b0);
    step(2, 8'h7e, 1'b0);
    step(2, 8'h7e, 1'b0);
    $display("test logic done");
  endtask : t_logic

  task automatic t_regs();
    ld({8'h78, 8'h02, 8'h79, 8'h03, 8'h74, 8'h77, 8'hfa, 8'h7b, 8'h55, 8'h74, 8'h00,
        8'he6, 8'he7, 8'h2a, 8'h88, 8'h30, 8'ha9, 8'h30, 8'he7, 8'he9, 8'h36, 8'h97});
    step(2, 8'h00, 1'b0);
    step(2, 8'h00, 1'b0);
    step(2, 8'h77, 1'b0);
    step(1, 8'h77, 1'b0);
    step(2, 8'h77, 1'b0);
    step(2, 8'h00, 1'b0);
    step(1, 8'h77, 1'b0);
    step(1, 8'h55, 1'b0);
    step(1, 8'hcc, 1'b0);
    step(2, 8'hcc, 1'b0);
    step(2, 8'hcc, 1'b0);
    step(1, 8'h77, 1'b0);
    step(1, 8'h02, 1'b0);
    step(1, 8'h79, 1'b0);
    step(1, 8'h02, 1'b0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_muldiv();
    ld({8'h74, 8'h0c, 8'hf5, 8'hf0, 8'h74, 8'h64, 8'h84, 8'ha4, 8'h84, 8'ha5});
    step(2, 8'h0c, 1'b0);
    step(2, 8'h0c, 1'b0);
    step(2, 8'h64, 1'b0);
    step(5, 8'h08, 1'b0);
    cmp("ovf", 16'h0000, {15'h0000, ovf_o});
    step(5, 8'h20, 1'b0);
    cmp("illegal", 16'h0000, {15'h0000, illegal_o});
    step(5, 8'h20, 1'b0);
    cmp("ovf", 16'h0001, {15'h0000, ovf_o});
    // an unsupported opcode runs as a one-cycle no-op and is flagged
    step(1, 8'h20, 1'b0);
    cmp("illegal", 16'h0001, {15'h0000, illegal_o});
    $display("test muldiv done");
  endtask : t_muldiv

  // forward jump over a load, then a backward jump onto it
  task automatic t_jump();
    seq_on = 1'b0;
    ld({8'h74, 8'h11, 8'h80, 8'h04, 8'h74, 8'h33, 8'h80, 8'h04, 8'h80, 8'hfa});
    step(2, 8'h11, 1'b0);
    step(3, 8'h11, 1'b0);
    step(3, 8'h11, 1'b0);
    step(2, 8'h33, 1'b0);
    step(3, 8'h33, 1'b0);
    step(1, 8'h33, 1'b0);
    $display("test jump done");
  endtask : t_jump

  // ------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    srst_i = 1'b1;
    repeat (12) @(negedge sys_clk_i);
    t_arith();
    t_logic();
    t_regs();
    t_muldiv();
    t_jump();
    report_and_stop();
  end

  // the programs need well under 1000 cycles; 4000 means a hang
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_fcd_core
